/* design/volume_mute_pkg.sv */
package volume_mute_pkg;

  // register offsets on the control port
  localparam logic [7:0] VOL_CFG_OFS   = 8'h03;
  localparam logic [7:0] LEFT_LVL_OFS  = 8'h04;
  localparam logic [7:0] RIGHT_LVL_OFS = 8'h05;
  localparam logic [7:0] OUT_CFG_OFS   = 8'h06;

  // field positions
  localparam int FADE_BIT      = 7;
  localparam int SIL_R_BIT     = 1;
  localparam int SIL_L_BIT     = 0;
  localparam int BRIDGE_EN_BIT = 7;
  localparam int RATE_LSB      = 4;
  localparam int AGAIN_LSB     = 2;
  localparam int BRIDGE_CH_BIT = 1;

  // writable bits of the volume configuration register
  localparam logic [7:0] VOL_CFG_WMASK = 8'h83;

  // values after reset
  localparam logic [7:0] VOL_CFG_RST = 8'h80;
  localparam logic [7:0] LEVEL_RST   = 8'hCF;
  localparam logic [7:0] OUT_CFG_RST = 8'h51;

  // level code landmarks
  localparam logic [7:0] LEVEL_UNITY  = 8'hCF;
  localparam logic [7:0] LEVEL_FLOOR  = 8'h07;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // register port request from the control-port engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // per-channel output drive status
  typedef struct packed {
    logic             silenced;
    logic             half_duty;
    logic signed [8:0] gain_half_db;
    logic [7:0]       level;
  } chan_out_s;

  // output stage settings
  typedef struct packed {
    logic       bridge_mono;
    logic [2:0] rate_sel;
    logic [1:0] analog_gain;
    logic       bridge_chan_left;
  } stage_out_s;

endpackage

/* design/volume_mute_control_regs.sv */
// How it works
// - bit 7 of the volume configuration register turns level fading on, and resets to 1.
// - bit 1 of that register silences the right channel, and resets to 0.
// - bit 0 of that register silences the left channel, and resets to 0.
// - a silenced channel keeps its blocks running and drives its outputs at 50/50 duty.
// - a level code steps the gain by 0.5 dB, with all ones giving +24 dB.
// - code 0xCF gives 0 dB and is the reset value of both level registers.
// - code 0x07 gives -100 dB and any code below it silences the channel.
// - left level sits at 0x04 and right level at 0x05, both read/write.
// - the output stage register at 0x06 is read/write with the bridge enable in bit 7.
// - bridge enable 0 gives two bridged channels, 1 gives one parallel mono output.
`timescale 1ns/1ns
`default_nettype none
module volume_mute_control_regs
  import volume_mute_pkg::*;
#(
  parameter int FADE_STEP = 1
)(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire reg_req_s   req,
  input  wire logic       sample_tick,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output chan_out_s       left_out,
  output chan_out_s       right_out,
  output stage_out_s      stage_out,
  output logic            blocks_active
);

  typedef struct packed {
    logic [7:0] vol_cfg;
    logic [7:0] left_lvl;
    logic [7:0] right_lvl;
    logic [7:0] out_cfg;
    logic [7:0] rd_data;
    logic       rd_valid;
    chan_out_s  left;
    chan_out_s  right;
    stage_out_s stage;
    logic       active;
  } state_s;

  state_s s_q;
  state_s s_d;

  // one fading step toward the target, never overshooting
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    logic [8:0] up;
    logic [8:0] dn;
    up = {1'b0, cur} + 9'(FADE_STEP);
    dn = {1'b0, cur} - 9'(FADE_STEP);
    if (cur < tgt)
      step_toward = (up >= {1'b0, tgt}) ? tgt : up[7:0];
    else if (cur > tgt)
      step_toward = (dn[8] || dn <= {1'b0, tgt}) ? tgt : dn[7:0];
    else
      step_toward = cur;
  endfunction

  // gain in half-decibel units relative to unity
  function automatic logic signed [8:0] half_db(input logic [7:0] code);
    half_db = $signed({1'b0, code}) - $signed({1'b0, LEVEL_UNITY});
  endfunction

  // silence decode shared by both channels; the floor is checked on the applied level
  function automatic logic chan_silenced(input logic sil_bit, input logic [7:0] code);
    chan_silenced = sil_bit || (code < LEVEL_FLOOR);
  endfunction

  // register reads, unmapped offsets answer zero
  function automatic logic [7:0] read_mux(input state_s s, input logic [7:0] a);
    case (a)
      VOL_CFG_OFS:   read_mux = s.vol_cfg;
      LEFT_LVL_OFS:  read_mux = s.left_lvl;
      RIGHT_LVL_OFS: read_mux = s.right_lvl;
      OUT_CFG_OFS:   read_mux = s.out_cfg;
      default:       read_mux = UNMAPPED_VAL;
    endcase
  endfunction

  // next-state logic: register file, level tracking and output drive
  always_comb
  begin
    logic [7:0] next_l;
    logic [7:0] next_r;
    logic       fade;
    next_l = s_q.left.level;
    next_r = s_q.right.level;
    fade   = s_q.vol_cfg[FADE_BIT];
    s_d    = s_q;
    // write decode; reserved configuration bits stay zero whatever is written
    if (req.wr)
    begin
      case (req.addr)
        VOL_CFG_OFS:   s_d.vol_cfg = req.wdata & VOL_CFG_WMASK;
        LEFT_LVL_OFS:  s_d.left_lvl = req.wdata;
        RIGHT_LVL_OFS: s_d.right_lvl = req.wdata;
        OUT_CFG_OFS:   s_d.out_cfg = req.wdata;
        default:       s_d.vol_cfg = s_q.vol_cfg;
      endcase
    end
    // read answers one cycle later, from the registers as they stood
    s_d.rd_valid = req.rd;
    if (req.rd)
      s_d.rd_data = read_mux(s_q, req.addr);
    // levels move only at sample boundaries so no sample sees a half-updated gain
    if (sample_tick)
    begin
      if (fade)
      begin
        next_l = step_toward(s_q.left.level, s_q.left_lvl);
        next_r = step_toward(s_q.right.level, s_q.right_lvl);
      end
      else
      begin
        next_l = s_q.left_lvl;
        next_r = s_q.right_lvl;
      end
    end
    s_d.left.level  = next_l;
    s_d.right.level = next_r;
    s_d.left.gain_half_db  = half_db(next_l);
    s_d.right.gain_half_db = half_db(next_r);
    // silence from the config bit or from a code under the floor
    s_d.left.silenced  = chan_silenced(s_q.vol_cfg[SIL_L_BIT], next_l);
    s_d.right.silenced = chan_silenced(s_q.vol_cfg[SIL_R_BIT], next_r);
    s_d.left.half_duty  = s_d.left.silenced;
    s_d.right.half_duty = s_d.right.silenced;
    // output stage fields follow the register
    s_d.stage.bridge_mono      = s_q.out_cfg[BRIDGE_EN_BIT];
    s_d.stage.rate_sel         = s_q.out_cfg[RATE_LSB +: 3];
    s_d.stage.analog_gain      = s_q.out_cfg[AGAIN_LSB +: 2];
    s_d.stage.bridge_chan_left = s_q.out_cfg[BRIDGE_CH_BIT];
    // silence is a drive choice, not a power-down, so the blocks stay up
    s_d.active = 1'b1;
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s_q.vol_cfg   <= VOL_CFG_RST;
      s_q.left_lvl  <= LEVEL_RST;
      s_q.right_lvl <= LEVEL_RST;
      s_q.out_cfg   <= OUT_CFG_RST;
      s_q.rd_data   <= UNMAPPED_VAL;
      s_q.rd_valid  <= 1'b0;
      s_q.left      <= '{silenced: 1'b0, half_duty: 1'b0, gain_half_db: 9'sh000,
                         level: LEVEL_RST};
      s_q.right     <= '{silenced: 1'b0, half_duty: 1'b0, gain_half_db: 9'sh000,
                         level: LEVEL_RST};
      s_q.stage     <= '{bridge_mono: OUT_CFG_RST[BRIDGE_EN_BIT],
                         rate_sel: OUT_CFG_RST[RATE_LSB +: 3],
                         analog_gain: OUT_CFG_RST[AGAIN_LSB +: 2],
                         bridge_chan_left: OUT_CFG_RST[BRIDGE_CH_BIT]};
      s_q.active    <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign rd_data       = s_q.rd_data;
  assign rd_valid      = s_q.rd_valid;
  assign left_out      = s_q.left;
  assign right_out     = s_q.right;
  assign stage_out     = s_q.stage;
  assign blocks_active = s_q.active;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // fade enable bit tracks the last write to bit 7
  fade_bit_a: assert property (
    req.wr && req.addr == VOL_CFG_OFS |=> s_q.vol_cfg[FADE_BIT] == $past(req.wdata[FADE_BIT]))
    else $error("fade bit not written");

  // right silence bit forces half duty on the right
  right_sil_a: assert property (
    s_q.vol_cfg[SIL_R_BIT] && !req.wr |=> right_out.silenced && right_out.half_duty)
    else $error("right channel not silenced");

  // left silence bit forces half duty on the left
  left_sil_a: assert property (
    s_q.vol_cfg[SIL_L_BIT] && !req.wr |=> left_out.silenced && left_out.half_duty)
    else $error("left channel not silenced");

  // half duty goes with silence; blocks are up from the first edge after reset
  half_duty_a: assert property (
    !$past(sys_rst) |-> (left_out.half_duty == left_out.silenced) &&
    (right_out.half_duty == right_out.silenced) && blocks_active)
    else $error("silence drive wrong");

  // gain in half decibels follows the applied level
  gain_map_a: assert property (
    left_out.gain_half_db == $signed({1'b0, left_out.level}) - 9'sd207)
    else $error("gain map wrong");

  // unity code gives zero gain
  unity_a: assert property (
    right_out.level == 8'hCF |-> right_out.gain_half_db == 9'sd0)
    else $error("unity code not 0 dB");

  // codes below the floor silence the channel
  floor_a: assert property (
    left_out.level < 8'h07 |-> left_out.silenced)
    else $error("low code not silenced");

  // the right channel obeys the same floor
  floor_r_a: assert property (
    right_out.level < 8'h07 |-> right_out.silenced)
    else $error("right low code not silenced");

  // level register read back a cycle after its write
  level_rw_a: assert property (
    req.wr && req.addr == LEFT_LVL_OFS ##1 req.rd && req.addr == LEFT_LVL_OFS && !req.wr
    |=> rd_valid && rd_data == $past(req.wdata, 2))
    else $error("left level readback wrong");

  // reserved configuration bits always read zero
  reserved_a: assert property (
    s_q.vol_cfg[6:2] == 5'h00)
    else $error("reserved bits set");

  // bridge mode follows bit 7 of the output stage register
  bridge_a: assert property (
    req.wr && req.addr == OUT_CFG_OFS |-> ##2 stage_out.bridge_mono == $past(req.wdata[7], 2))
    else $error("bridge mode not applied");

  // without fading the level jumps on the sample tick
  jump_a: assert property (
    sample_tick && !s_q.vol_cfg[FADE_BIT] |=> left_out.level == $past(s_q.left_lvl))
    else $error("level did not jump");

  // with fading each tick moves at most one step
  ramp_a: assert property (
    sample_tick && s_q.vol_cfg[FADE_BIT] && FADE_STEP == 1 |=>
    (left_out.level - $past(left_out.level) == 8'h01) ||
    ($past(left_out.level) - left_out.level == 8'h01) ||
    (left_out.level == $past(left_out.level)))
    else $error("fade step too large");

  // right gain follows its applied level as well
  gain_map_r_a: assert property (
    right_out.gain_half_db == $signed({1'b0, right_out.level}) - 9'sd207)
    else $error("right gain map wrong");

  // right level also jumps on the tick without fading
  jump_r_a: assert property (
    sample_tick && !s_q.vol_cfg[FADE_BIT] |=> right_out.level == $past(s_q.right_lvl))
    else $error("right level did not jump");

  // between ticks the applied left level never moves
  hold_l_a: assert property (
    !sample_tick |=> left_out.level == $past(left_out.level))
    else $error("left level moved off tick");

  // between ticks the applied right level never moves
  hold_r_a: assert property (
    !sample_tick |=> right_out.level == $past(right_out.level))
    else $error("right level moved off tick");

  // stage fields are the register as it stood a cycle earlier
  stage_copy_a: assert property (
    !$past(sys_rst) |-> stage_out == $past(s_q.out_cfg[7:1]))
    else $error("stage fields wrong");

  // silence bits track the last configuration write
  sil_bits_a: assert property (
    req.wr && req.addr == VOL_CFG_OFS |=> s_q.vol_cfg[1:0] == $past(req.wdata[1:0]))
    else $error("silence bits not written");

  // right level read back a cycle after its write
  right_rw_a: assert property (
    req.wr && req.addr == RIGHT_LVL_OFS ##1 req.rd && req.addr == RIGHT_LVL_OFS && !req.wr
    |=> rd_valid && rd_data == $past(req.wdata, 2))
    else $error("right level readback wrong");

  // a write elsewhere leaves the left level register alone
  left_keep_a: assert property (
    req.wr && req.addr != LEFT_LVL_OFS |=> $stable(s_q.left_lvl))
    else $error("left level disturbed");

  // every read answers exactly one cycle later
  rd_answer_a: assert property (
    req.rd |=> rd_valid)
    else $error("read not answered");

  // no answer appears without a read
  rd_quiet_a: assert property (
    !req.rd |=> !rd_valid)
    else $error("answer without read");

  // read data holds until the next read
  rd_hold_a: assert property (
    !req.rd |=> $stable(rd_data))
    else $error("read data not held");

  // offsets outside the map read as zero
  unmapped_a: assert property (
    req.rd && (req.addr < VOL_CFG_OFS || req.addr > OUT_CFG_OFS)
    |=> rd_data == UNMAPPED_VAL)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

/* tb/volume_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// stands in for the control-port engine, one byte access at a time
module volume_host_model
  import volume_mute_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output var  reg_req_s   req
);
  initial req = '0;
  // requests change at the falling edge and stand over one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr    = 1'b0;
    req.wdata = ~d; // released data shows no stale value
  endtask
  // called at a falling edge, so a read may follow a write with no idle cycle;
  // rd_valid stands one cycle only and is looked at on the falling edge inside it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (rd_valid === 1'b1)
      begin
        ok = 1'b1;
        d  = rd_data;
      end
      @(negedge sys_clk);
    end
  endtask
  // only fade and silence bits are ever set
  task automatic cfg(input logic fade, input logic sil_r, input logic sil_l);
    wr(VOL_CFG_OFS, {fade, 5'h00, sil_r, sil_l});
  endtask
endmodule
`default_nettype wire

/* tb/volume_mute_control_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module volume_mute_control_regs_test;
  import volume_mute_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic       sys_clk, sys_rst, sample_tick, rd_valid, blocks_active, ok;
  logic [7:0] rd_data, v;
  reg_req_s   req;
  chan_out_s  left_out, right_out;
  stage_out_s stage_out;
  int         n_errors, n_compared;
  // write then read back; read-only bits and the unmapped offset show in e
  row_s rows [5] = '{'{VOL_CFG_OFS, 8'hFF, 8'h83}, '{LEFT_LVL_OFS, 8'h5A, 8'h5A},
    '{RIGHT_LVL_OFS, 8'hA5, 8'hA5}, '{OUT_CFG_OFS, 8'hAE, 8'hAE}, '{8'h07, 8'h55, 8'h00}};

  volume_mute_control_regs #(.FADE_STEP(1)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .req(req), .sample_tick(sample_tick), .rd_data(rd_data), .rd_valid(rd_valid),
    .left_out(left_out), .right_out(right_out), .stage_out(stage_out),
    .blocks_active(blocks_active));
  volume_host_model host (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .req(req));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // a read that never answers ends the run rather than hanging it
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v, ok);
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] read answer expected 1 seen 0");
      stop_test();
    end
    else
      chk("read data", {1'b0, e}, {1'b0, v});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one sample pulse, then one more edge so the channel outputs land
  task automatic tick;
    @(negedge sys_clk);
    sample_tick = 1'b1;
    settle(1);
    sample_tick = 1'b0;
    settle(1);
  endtask

  // main sequence: reset values, register table, sample path, second reset
  initial
  begin
    n_errors    = 0;
    n_compared  = 0;
    sys_rst     = 1'b1;
    sample_tick = 1'b0;
    settle(16);
    sys_rst = 1'b0;
    settle(1);
    chk("blocks active", 9'h001, blocks_active);
    chk("left level", LEVEL_RST, left_out.level);
    chk("right level", LEVEL_RST, right_out.level);
    chk("left gain", 9'h000, left_out.gain_half_db);
    rdchk(VOL_CFG_OFS, 8'h80);
    rdchk(LEFT_LVL_OFS, LEVEL_RST);
    rdchk(RIGHT_LVL_OFS, LEVEL_RST);
    rdchk(OUT_CFG_OFS, 8'h51);
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk("stage", 9'h057, {2'b00, stage_out});
    host.cfg(1'b0, 1'b0, 1'b0);
    host.wr(LEFT_LVL_OFS, 8'hFF);
    host.wr(RIGHT_LVL_OFS, LEVEL_FLOOR);
    tick();
    chk("left level", 9'h0FF, left_out.level);
    chk("left gain", 9'h030, left_out.gain_half_db);
    chk("right gain", 9'h138, right_out.gain_half_db);
    chk("right silenced", 9'h000, right_out.silenced);
    host.wr(RIGHT_LVL_OFS, 8'h06);
    tick();
    chk("right silenced", 9'h001, right_out.silenced);
    chk("right half duty", 9'h001, right_out.half_duty);
    host.wr(RIGHT_LVL_OFS, LEVEL_UNITY);
    tick();
    host.cfg(1'b0, 1'b0, 1'b1);
    settle(3);
    chk("left silenced", 9'h001, left_out.silenced);
    chk("right silenced", 9'h000, right_out.silenced);
    host.cfg(1'b0, 1'b1, 1'b0);
    settle(3);
    chk("left silenced", 9'h000, left_out.silenced);
    chk("right half duty", 9'h001, right_out.half_duty);
    chk("blocks active", 9'h001, blocks_active);
    host.cfg(1'b1, 1'b0, 1'b0);
    host.wr(LEFT_LVL_OFS, 8'hFD);
    for (int k = 0; k < 3; k++)
    begin
      tick();
      chk("fading level", (k == 0) ? 9'h0FE : 9'h0FD, left_out.level);
    end
    host.wr(OUT_CFG_OFS, 8'h01);
    settle(3);
    chk("bridge mono", 9'h000, stage_out.bridge_mono);
    sys_rst = 1'b1;
    settle(2);
    sys_rst = 1'b0;
    settle(1);
    rdchk(VOL_CFG_OFS, 8'h80);
    chk("left level", LEVEL_RST, left_out.level);
    stop_test();
  end
endmodule
`default_nettype wire
